/* File: rtl/ast_consts.vh */
// ast_consts.vh: constants of the asynchronous serial transceiver
// assumes inclusion by bare name from rtl/ design files
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH
// register byte offsets on the axi4-lite bus
`define AST_OFS_TXDATA 8'h00
`define AST_OFS_RXDATA 8'h04
`define AST_OFS_STATUS 8'h08
`define AST_OFS_FORMAT 8'h0C
`define AST_OFS_CTRL 8'h10
`define AST_OFS_CLKDIV 8'h14
// format field positions
`define AST_FMT_LEN_LO 0
`define AST_FMT_LEN_HI 1
`define AST_FMT_TWO_STOP 2
`define AST_FMT_PAR_EVEN 3
`define AST_FMT_PAR_OMIT 4
// status bit positions
`define AST_ST_PAR_ERR 0
`define AST_ST_OVERRUN 1
`define AST_ST_TX_EMPTY 2
`define AST_ST_FRAME_ERR 3
`define AST_ST_CHAR_READY 4
`define AST_ST_CHAR_DONE 5
// reset values
`define AST_FORMAT_RST 5'h03
`define AST_DIV_RST 16'h0008
// 160 khz maximum bit clock, 20 mhz system clock
`define AST_BITCLK_MAX_KHZ 160
`define AST_CLK_KHZ 20000
// ceiling of clock over bit clock limit, sized for the 16-bit divisor
`define AST_DIV_MIN 16'h007D
`define AST_OVERSAMPLE 16
`define AST_RESP_OKAY 2'h0
`define AST_RESP_SLVERR 2'h2
`endif

/* File: rtl/ast_bit_clock.v */
// ast_bit_clock.v: divider making a one-cycle 16x bit-clock enable
// assumes divisor written by software; divisor below the minimum is clamped
`timescale 1ns/1ns
`include "ast_consts.vh"
module ast_bit_clock (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // control
   input wire run,
   input wire [15:0] divisor,
   // enable out
   output reg tick_r
);
   reg [15:0] cnt_r;
   wire [15:0] lim;
   // clamp keeps the tick at or below the maximum bit clock rate
   assign lim = (divisor < `AST_DIV_MIN) ? `AST_DIV_MIN : divisor;
   always @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (cnt_r >= lim - 16'h0001) begin
         cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end
endmodule // ast_bit_clock

/* File: rtl/ast_transceiver.v */
// ast_transceiver.v: full-duplex async serial transceiver, axi4-lite registers
// assumes one 20 mhz clock; serial_in is asynchronous and synchronised here
`timescale 1ns/1ns
`include "ast_consts.vh"
module ast_transceiver (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // serial line
   input wire serial_in,
   output reg serial_out_r,
   // status lines
   output reg tx_holding_empty_r,
   output reg char_done_r,
   output reg rx_char_ready_r
);
   localparam TX_IDLE = 2'd0;
   localparam TX_SHIFT = 2'd1;
   localparam RX_IDLE = 2'd0;
   localparam RX_START = 2'd1;
   localparam RX_BITS = 2'd2;

   // control registers
   reg [4:0] format_r;
   reg [15:0] rx_div_r;
   reg [15:0] tx_div_r;
   reg power_on_clear_r;
   reg [7:0] tx_hold_r;
   reg [7:0] rx_hold_r;
   reg parity_err_status_r;
   reg frame_err_status_r;
   reg overrun_r;
   wire rx_tick;
   wire tx_tick;

   // each direction owns a clamped divider
   ast_bit_clock u_rx_clk (
      .aclk(aclk), .aresetn(aresetn), .run(!power_on_clear_r),
      .divisor(rx_div_r), .tick_r(rx_tick));
   ast_bit_clock u_tx_clk (
      .aclk(aclk), .aresetn(aresetn), .run(!power_on_clear_r),
      .divisor(tx_div_r), .tick_r(tx_tick));

   // number of data bits: 5 plus the two length bits
   function [3:0] data_bits;
      input [4:0] f;
      begin
         data_bits = 4'd5 + {2'b00, f[`AST_FMT_LEN_HI], f[`AST_FMT_LEN_LO]};
      end
   endfunction

   // parity bit to send/expect: odd when low select, even when high
   function par_bit;
      input [7:0] d;
      input [4:0] f;
      begin
         par_bit = (^d) ^ !f[`AST_FMT_PAR_EVEN];
      end
   endfunction

   function [7:0] len_mask;
      input [4:0] f;
      begin
         len_mask = 8'hFF >> (4'd8 - data_bits(f));
      end
   endfunction

   // stop length in ticks: 16, 24 for 5-bit extended, 32
   function [5:0] stop_ticks;
      input [4:0] f;
      begin
         if (!f[`AST_FMT_TWO_STOP])
            stop_ticks = 6'd16;
         else if (data_bits(f) == 4'd5)
            stop_ticks = 6'd24;
         else
            stop_ticks = 6'd32;
      end
   endfunction

   // transmitter
   reg [1:0] tx_st_r;
   reg [9:0] tx_sh_r;
   reg [3:0] tx_bits_r;
   reg [3:0] tx_sub_r;
   reg [5:0] tx_stop_r;
   reg tx_in_stop_r;
   reg tx_load_pend_r;
   wire [7:0] tx_d;
   assign tx_d = tx_hold_r & len_mask(format_r);

   always @(posedge aclk) begin
      if (!aresetn || power_on_clear_r) begin
         tx_st_r <= TX_IDLE;
         serial_out_r <= 1'b1;
         char_done_r <= 1'b1;
         tx_sh_r <= 10'h000;
         tx_bits_r <= 4'h0;
         tx_sub_r <= 4'h0;
         tx_stop_r <= 6'h00;
         tx_in_stop_r <= 1'b0;
      end else if (tx_tick) begin
         case (tx_st_r)
            TX_IDLE: begin
               serial_out_r <= 1'b1;
               if (tx_load_pend_r) begin
                  tx_st_r <= TX_SHIFT;
                  serial_out_r <= 1'b0;
                  char_done_r <= 1'b0;
                  // parity sits just above the last data bit, whatever the length
                  tx_sh_r <= {2'b00, tx_d} |
                     ({9'h000, par_bit(tx_d, format_r)} << data_bits(format_r));
                  tx_bits_r <= data_bits(format_r) +
                     {3'b000, !format_r[`AST_FMT_PAR_OMIT]};
                  tx_sub_r <= 4'h0;
                  tx_in_stop_r <= 1'b0;
               end
            end
            TX_SHIFT: begin
               tx_sub_r <= tx_sub_r + 4'h1;
               if (tx_in_stop_r) begin
                  tx_stop_r <= tx_stop_r - 6'h01;
                  // idle one tick early so a queued start lands on the stop end
                  if (tx_stop_r == 6'h02) begin
                     char_done_r <= 1'b1;
                     tx_st_r <= TX_IDLE;
                  end
               end else if (tx_sub_r == 4'hF) begin
                  if (tx_bits_r == 4'h0) begin
                     tx_in_stop_r <= 1'b1;
                     serial_out_r <= 1'b1;
                     tx_stop_r <= stop_ticks(format_r);
                  end else begin
                     serial_out_r <= tx_sh_r[0];
                     tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                     tx_bits_r <= tx_bits_r - 4'h1;
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // receiver: two-flop synchroniser then state machine
   reg rx_sync1_r;
   reg rx_sync2_r;
   reg rx_prev_r;
   reg [1:0] rx_st_r;
   reg [3:0] rx_sub_r;
   reg [3:0] rx_left_r;
   reg [8:0] rx_sh_r;
   reg rx_frame_err;
   wire [3:0] rx_total;
   assign rx_total = data_bits(format_r) + {3'b000, !format_r[`AST_FMT_PAR_OMIT]};

   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync1_r <= 1'b1;
         rx_sync2_r <= 1'b1;
      end else begin
         rx_sync1_r <= serial_in;
         rx_sync2_r <= rx_sync1_r;
      end
   end

   reg rx_done_r;
   reg [7:0] rx_word;
   always @* begin
      rx_word = 8'h00;
      // shift register filled from the top; right-justify
      rx_word = (rx_sh_r[8:1] >> (4'd8 - data_bits(format_r))) & len_mask(format_r);
      if (format_r[`AST_FMT_PAR_OMIT])
         rx_word = (rx_sh_r[8:1] >> (4'd8 - data_bits(format_r))) & len_mask(format_r);
      else
         rx_word = (rx_sh_r[7:0] >> (4'd8 - data_bits(format_r))) & len_mask(format_r);
      rx_frame_err = !rx_sync2_r;
   end

   always @(posedge aclk) begin
      if (!aresetn || power_on_clear_r) begin
         rx_st_r <= RX_IDLE;
         rx_prev_r <= 1'b1;
         rx_sub_r <= 4'h0;
         rx_left_r <= 4'h0;
         rx_sh_r <= 9'h000;
         rx_done_r <= 1'b0;
      end else begin
         rx_done_r <= 1'b0;
         if (rx_tick) begin
            rx_prev_r <= rx_sync2_r;
            rx_sub_r <= rx_sub_r + 4'h1;
            case (rx_st_r)
               RX_IDLE:
                  if (rx_prev_r && !rx_sync2_r) begin
                     rx_st_r <= RX_START;
                     rx_sub_r <= 4'h1;
                  end
               RX_START:
                  if (rx_sub_r == 4'h7) begin
                     if (rx_sync2_r)
                        rx_st_r <= RX_IDLE;
                     else begin
                        rx_st_r <= RX_BITS;
                        rx_sub_r <= 4'h8;
                        rx_left_r <= rx_total;
                        rx_sh_r <= 9'h000;
                     end
                  end
               RX_BITS:
                  if (rx_sub_r == 4'h7) begin
                     if (rx_left_r == 4'h0) begin
                        rx_done_r <= 1'b1;
                        rx_st_r <= RX_IDLE;
                        rx_prev_r <= 1'b0;
                     end else begin
                        rx_sh_r <= {rx_sync2_r, rx_sh_r[8:1]};
                        rx_left_r <= rx_left_r - 4'h1;
                     end
                  end
               default: rx_st_r <= RX_IDLE;
            endcase
         end
      end
   end

   // parity check over data plus received parity bit
   wire rx_par_fail;
   // even sense wants an even count of ones, odd sense an odd count
   assign rx_par_fail = !format_r[`AST_FMT_PAR_OMIT] &&
      ((^rx_sh_r) == format_r[`AST_FMT_PAR_EVEN]);

   // axi4-lite slave: one outstanding write and read, 1-cycle answers
   reg aw_got_r;
   reg w_got_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   wire wr_fire;
   wire [5:0] status_word;
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   assign status_word = {char_done_r, rx_char_ready_r, frame_err_status_r,
      tx_holding_empty_r, overrun_r, parity_err_status_r};

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AST_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `AST_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         format_r <= `AST_FORMAT_RST;
         rx_div_r <= `AST_DIV_RST;
         tx_div_r <= `AST_DIV_RST;
         power_on_clear_r <= 1'b0;
         tx_hold_r <= 8'h00;
         tx_holding_empty_r <= 1'b1;
         tx_load_pend_r <= 1'b0;
         rx_hold_r <= 8'h00;
         rx_char_ready_r <= 1'b0;
         parity_err_status_r <= 1'b0;
         frame_err_status_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // transmit handover to shifter
         if (tx_tick && tx_st_r == TX_IDLE && tx_load_pend_r) begin
            tx_load_pend_r <= 1'b0;
            tx_holding_empty_r <= 1'b1;
         end
         // receive completion; set wins over software clear
         if (rx_done_r) begin
            rx_hold_r <= rx_word;
            rx_char_ready_r <= 1'b1;
            overrun_r <= rx_char_ready_r;
            frame_err_status_r <= rx_frame_err;
            parity_err_status_r <= rx_par_fail;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `AST_RESP_OKAY;
            if (aw_addr_r[7:2] == `AST_OFS_TXDATA >> 2) begin
               if (w_strb_r[0] && tx_holding_empty_r) begin
                  tx_hold_r <= w_data_r[7:0];
                  tx_holding_empty_r <= 1'b0;
                  tx_load_pend_r <= 1'b1;
               end
            end else if (aw_addr_r[7:2] == `AST_OFS_FORMAT >> 2) begin
               if (w_strb_r[0])
                  format_r <= w_data_r[4:0];
            end else if (aw_addr_r[7:2] == `AST_OFS_CTRL >> 2) begin
               if (w_strb_r[0]) begin
                  power_on_clear_r <= w_data_r[1];
                  if (w_data_r[0] && !rx_done_r)
                     rx_char_ready_r <= 1'b0;
               end
            end else if (aw_addr_r[7:2] == `AST_OFS_CLKDIV >> 2) begin
               if (w_strb_r[1:0] == 2'h3)
                  rx_div_r <= w_data_r[15:0];
               if (w_strb_r[3:2] == 2'h3)
                  tx_div_r <= w_data_r[31:16];
            end else if (aw_addr_r[7:2] != `AST_OFS_RXDATA >> 2 &&
                  aw_addr_r[7:2] != `AST_OFS_STATUS >> 2)
               s_axi_bresp <= `AST_RESP_SLVERR;
         end
         // power-on clear empties the holding and status registers; format and divisors keep their values
         if (power_on_clear_r) begin
            tx_holding_empty_r <= 1'b1;
            tx_load_pend_r <= 1'b0;
            rx_hold_r <= 8'h00;
            rx_char_ready_r <= 1'b0;
            overrun_r <= 1'b0;
            frame_err_status_r <= 1'b0;
            parity_err_status_r <= 1'b0;
         end
         // read channel
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `AST_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[7:2] == `AST_OFS_TXDATA >> 2)
               s_axi_rdata <= {24'h000000, tx_hold_r};
            else if (s_axi_araddr[7:2] == `AST_OFS_RXDATA >> 2)
               s_axi_rdata <= {24'h000000, rx_hold_r};
            else if (s_axi_araddr[7:2] == `AST_OFS_STATUS >> 2)
               s_axi_rdata <= {26'h0, status_word};
            else if (s_axi_araddr[7:2] == `AST_OFS_FORMAT >> 2)
               s_axi_rdata <= {27'h0, format_r};
            else if (s_axi_araddr[7:2] == `AST_OFS_CTRL >> 2)
               s_axi_rdata <= {30'h0, power_on_clear_r, 1'b0};
            else if (s_axi_araddr[7:2] == `AST_OFS_CLKDIV >> 2)
               s_axi_rdata <= {tx_div_r, rx_div_r};
            else
               s_axi_rresp <= `AST_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // tx and rx processes share only format and registers
endmodule // ast_transceiver

/* File: testbench/ast_transceiver_assertions.sv */
// ast_transceiver_assertions.sv: port checks of the serial transceiver
// assumes binding into ast_transceiver; one clock, sync active-low reset
`timescale 1ns/1ns
`include "ast_consts.vh"
module ast_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   // serial and status
   input wire serial_out_r,
   input wire tx_holding_empty_r,
   input wire char_done_r,
   input wire rx_char_ready_r
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   localparam int DONE_MIN = 120;
   reg [15:0] done_cnt_r;
   // saturates so a long idle cannot wrap to a short count
   always @(posedge aclk) begin
      if (!aresetn || !char_done_r)
         done_cnt_r <= 16'h0000;
      else if (done_cnt_r != 16'hFFFF)
         done_cnt_r <= done_cnt_r + 16'h0001;
   end
   sequence s_ctrl_clear;
      s_axi_awvalid && s_axi_awready && s_axi_awaddr == `AST_OFS_CTRL &&
      s_axi_wvalid && s_axi_wready && s_axi_wdata[0];
   endsequence
   sequence s_start_edge;
      // char done falls on the same edge as the line, so look one back
      $fell(serial_out_r) && $past(char_done_r);
   endsequence
   property p_reset;
      disable iff (1'b0)
      !aresetn |=> serial_out_r && char_done_r && tx_holding_empty_r && !rx_char_ready_r;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not at reset levels");
   property p_done_gap;
      s_start_edge |-> done_cnt_r >= DONE_MIN;
   endproperty
   a_done_gap: assert property (p_done_gap) else $error("char done pulse too short");
   property p_done_drop;
      s_start_edge |-> !char_done_r;
   endproperty
   a_done_drop: assert property (p_done_drop) else $error("char done kept past start");
   property p_done_rise;
      $rose(char_done_r) |-> serial_out_r;
   endproperty
   a_done_rise: assert property (p_done_rise) else $error("char done rose on space");
   property p_idle;
      char_done_r && tx_holding_empty_r |=> serial_out_r;
   endproperty
   a_idle: assert property (p_idle) else $error("line left mark while idle");
   property p_move;
      $fell(tx_holding_empty_r) && char_done_r |-> ##[1:300] tx_holding_empty_r;
   endproperty
   a_move: assert property (p_move) else $error("held char not moved to shifter");
   property p_clear;
      s_ctrl_clear |-> ##[1:3] !rx_char_ready_r;
   endproperty
   a_clear: assert property (p_clear) else $error("char ready not cleared");
   property p_keep;
      $fell(rx_char_ready_r) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) ||
         $past(s_axi_wvalid, 3);
   endproperty
   a_keep: assert property (p_keep) else $error("char ready dropped by itself");
endmodule // ast_chk

bind ast_transceiver ast_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .serial_out_r(serial_out_r), .tx_holding_empty_r(tx_holding_empty_r),
   .char_done_r(char_done_r), .rx_char_ready_r(rx_char_ready_r));

/* File: testbench/ast_line_partner.sv */
// ast_line_partner.sv: far end of the serial line, sends and samples frames
// assumes a 16x tick of 125 clocks, so one bit lasts 2000 clocks
`timescale 1ns/1ns
module ast_line_partner #(
   parameter BIT_CLKS = 2000
) (
   // clock
   input wire aclk,
   // serial line
   input wire serial_out_r,
   output reg serial_in
);
   initial serial_in = 1'b1;
   // frame bits lsb first, start in bit 0; line back to mark afterwards
   task send(input [15:0] f, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            serial_in <= f[i];
            repeat (BIT_CLKS) @(posedge aclk);
         end
         serial_in <= 1'b1;
      end
   endtask
   // space far shorter than half a bit
   task noise;
      begin
         serial_in <= 1'b0;
         repeat (BIT_CLKS / 4) @(posedge aclk);
         serial_in <= 1'b1;
      end
   endtask
   // samples at bit centres; returns before the next start edge
   task grab(output [15:0] f, input integer n);
      integer i;
      begin
         f = 16'hFFFF;
         @(negedge serial_out_r);
         repeat (BIT_CLKS / 2) @(posedge aclk);
         for (i = 0; i < n; i = i + 1) begin
            f[i] = serial_out_r;
            if (i < n - 1)
               repeat (BIT_CLKS) @(posedge aclk);
         end
      end
   endtask
endmodule // ast_line_partner

/* File: testbench/ast_transceiver_tb.sv */
// ast_transceiver_tb.sv: register-level test of the serial transceiver
// assumes the line partner at the serial pins and a 20 mhz clock
`timescale 1ns/1ns
`include "ast_consts.vh"
module ast_transceiver_tb;
   localparam integer BIT_CLKS = 2000;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] awaddr = 8'h00;
   reg [31:0] wdata = 32'h00000000;
   reg [7:0] araddr = 8'h00;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire serial_in, serial_out_r, tx_holding_empty_r, char_done_r, rx_char_ready_r;
   wire [31:0] pins = {28'h0, serial_out_r, char_done_r, tx_holding_empty_r, rx_char_ready_r};
   integer n_mismatch = 0;
   integer total_checks = 0;
   integer cycles = 0;
   integer i;
   reg [15:0] f, g;
   always #25 aclk = ~aclk;
   ast_transceiver DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_in(serial_in), .serial_out_r(serial_out_r),
      .tx_holding_empty_r(tx_holding_empty_r), .char_done_r(char_done_r),
      .rx_char_ready_r(rx_char_ready_r));
   ast_line_partner #(.BIT_CLKS(BIT_CLKS)) u_line (
      .aclk(aclk), .serial_out_r(serial_out_r), .serial_in(serial_in));
   task close_out;
      begin
         if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 100000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (awvalid && awready)
               awvalid <= 1'b0;
            if (wvalid && wready)
               wvalid <= 1'b0;
         end while (!bvalid);
         bready <= 1'b0;
         chk({30'h0, bresp}, 32'h0);
      end
   endtask
   task rdc(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (arvalid && arready)
               arvalid <= 1'b0;
         end while (!rvalid);
         rready <= 1'b0;
         chk(rdata & m, e);
         chk({30'h0, rresp}, {30'h0, er});
      end
   endtask
   // expected frame, lsb first, stop bits fill the top
   function [15:0] mk(input [7:0] d, input integer nb, input pe, input ev);
      integer k;
      reg [7:0] msk;
      begin
         msk = (8'h01 << nb) - 8'h01;
         mk = 16'hFFFF;
         mk[0] = 1'b0;
         for (k = 0; k < nb; k = k + 1)
            mk[k + 1] = d[k];
         if (pe)
            mk[nb + 1] = (^(d & msk)) ^ ~ev;
      end
   endfunction
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(pins, 32'hE);
      rdc(`AST_OFS_STATUS, 32'h3F, 32'h24, 2'h0);
      rdc(`AST_OFS_FORMAT, 32'h1F, 32'h03, 2'h0);
      rdc(`AST_OFS_CLKDIV, 32'hFFFFFFFF, 32'h00080008, 2'h0);
      rdc(8'h18, 32'h0, 32'h0, 2'h2);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`AST_OFS_FORMAT, i);
         rdc(`AST_OFS_FORMAT, 32'h1F, i, 2'h0);
      end
      wr(`AST_OFS_CLKDIV, 32'h007D007D);
      wr(`AST_OFS_FORMAT, 32'h0B);
      fork
         begin
            wr(`AST_OFS_TXDATA, 32'hA5);
            wait (tx_holding_empty_r === 1'b1);
            wr(`AST_OFS_TXDATA, 32'h5A);
         end
         begin
            u_line.grab(f, 11);
            u_line.grab(g, 11);
            chk(f, mk(8'hA5, 8, 1, 1));
            chk(g, mk(8'h5A, 8, 1, 1));
         end
         begin
            u_line.send(mk(8'h3C, 8, 1, 1), 11);
            wait (rx_char_ready_r === 1'b1);
            rdc(`AST_OFS_RXDATA, 32'hFF, 32'h3C, 2'h0);
            rdc(`AST_OFS_STATUS, 32'h1B, 32'h10, 2'h0);
            u_line.send(mk(8'hC3, 8, 1, 1) ^ 16'h0200, 11);
            repeat (10) @(posedge aclk);
            rdc(`AST_OFS_STATUS, 32'h1B, 32'h13, 2'h0);
            rdc(`AST_OFS_RXDATA, 32'hFF, 32'hC3, 2'h0);
         end
      join
      repeat (BIT_CLKS) @(posedge aclk);
      chk(pins, 32'hF);
      wr(`AST_OFS_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      chk(pins & 32'h1, 32'h0);
      wr(`AST_OFS_FORMAT, 32'h14);
      fork
         begin
            fork
               wr(`AST_OFS_TXDATA, 32'hF3);
               u_line.grab(f, 7);
            join
            chk(f, mk(8'h13, 5, 0, 0));
            repeat (BIT_CLKS * 3 / 4) @(posedge aclk);
            chk(pins & 32'h4, 32'h0);
            repeat (BIT_CLKS * 7 / 20) @(posedge aclk);
            chk(pins & 32'h4, 32'h4);
         end
         begin
            u_line.noise;
            repeat (BIT_CLKS * 2) @(posedge aclk);
            chk(pins & 32'h1, 32'h0);
            u_line.send(mk(8'h0A, 5, 0, 0) & 16'hFFBF, 7);
            repeat (10) @(posedge aclk);
            rdc(`AST_OFS_STATUS, 32'h1B, 32'h18, 2'h0);
            rdc(`AST_OFS_RXDATA, 32'hFF, 32'h0A, 2'h0);
         end
      join
      wr(`AST_OFS_CTRL, 32'h2);
      repeat (2) @(posedge aclk);
      chk(pins, 32'hE);
      rdc(`AST_OFS_STATUS, 32'h3F, 32'h24, 2'h0);
      rdc(`AST_OFS_CTRL, 32'h3, 32'h2, 2'h0);
      wr(`AST_OFS_CTRL, 32'h0);
      close_out;
   end
endmodule // ast_transceiver_tb
